// file: rtl/bgb_guard_block.sv
// Two-hand control supervisor with AXI4-Lite registers and interrupt
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module bgb_guard_block
  import bgb_pkg::*;
#(
  parameter logic [15:0] CYCLES_PER_MS_P = CYCLES_PER_MS
) (
  input  wire logic        clk,                 // Controller clock, 50 MHz
  input  wire logic        reset,               // Async reset, active high
  input  wire logic        first_button_in,     // First pushbutton, high = pressed
  input  wire logic        second_button_in,    // Second pushbutton, high = pressed
  output logic             release_permit_out,  // Safety release, high = permit
  output logic             ready,               // Block active
  output logic             error,               // Error present
  output logic [15:0]      diagnostic_code,     // Current state or error code
  output logic             irq,                 // Level interrupt
  input  wire logic [3:0]  s_axi_awaddr,        // Write address
  input  wire logic        s_axi_awvalid,       // Write address valid
  output logic             s_axi_awready,       // Write address ready
  input  wire logic [31:0] s_axi_wdata,         // Write data
  input  wire logic [3:0]  s_axi_wstrb,         // Write byte strobes
  input  wire logic        s_axi_wvalid,        // Write data valid
  output logic             s_axi_wready,        // Write data ready
  output logic [1:0]       s_axi_bresp,         // Write response
  output logic             s_axi_bvalid,        // Write response valid
  input  wire logic        s_axi_bready,        // Write response ready
  input  wire logic [3:0]  s_axi_araddr,        // Read address
  input  wire logic        s_axi_arvalid,       // Read address valid
  output logic             s_axi_arready,       // Read address ready
  output logic [31:0]      s_axi_rdata,         // Read data
  output logic [1:0]       s_axi_rresp,         // Read response
  output logic             s_axi_rvalid,        // Read data valid
  input  wire logic        s_axi_rready         // Read data ready
);

  bgb_state_t  state;
  bgb_state_t  next_state;
  logic [15:0] err_code;
  logic [15:0] next_err_code;
  logic [15:0] next_diag;
  logic        next_ready;
  logic        next_error;
  logic        next_permit;
  logic        enable;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [2:0]  events;
  logic        win_start;
  logic        win_run;
  logic        win_expired;

  // Button decodes
  wire both_on  = first_button_in & second_button_in;
  wire none_on  = !first_button_in & !second_button_in;
  wire only_b1  = first_button_in & !second_button_in;
  wire only_b2  = !first_button_in & second_button_in;

  // Window timer runs only while exactly one press is pending
  assign win_run = (state == BGB_FIRST_ON) || (state == BGB_SECOND_ON);

  bgb_window_timer #(
    .CYCLES_PER_MS_P (CYCLES_PER_MS_P)
  ) u_window (
    .clk     (clk),
    .reset   (reset),
    .restart (win_start),
    .run     (win_run),
    .expired (win_expired)
  );

  // Next-state logic; disable override sits last so it wins
  always_comb begin
    next_state    = state;
    next_err_code = err_code;
    win_start     = 1'b0;
    case (state)
      BGB_IDLE: begin
        next_state = BGB_INIT;
      end
      BGB_INIT: begin
        if (both_on) begin
          next_state    = BGB_ERROR;
          next_err_code = DIAG_ERR_B12;
        end else if (only_b1) begin
          next_state    = BGB_ERROR;
          next_err_code = DIAG_ERR_B1;
        end else if (only_b2) begin
          next_state    = BGB_ERROR;
          next_err_code = DIAG_ERR_B2;
        end else begin
          next_state = BGB_RELEASED;
        end
      end
      BGB_RELEASED: begin
        if (both_on) begin
          next_state = BGB_ACTUATED;
        end else if (only_b1) begin
          next_state = BGB_FIRST_ON;
          win_start  = 1'b1;
        end else if (only_b2) begin
          next_state = BGB_SECOND_ON;
          win_start  = 1'b1;
        end
      end
      BGB_FIRST_ON, BGB_SECOND_ON: begin
        if (win_expired) begin
          if (both_on) begin
            next_state    = BGB_ERROR;
            next_err_code = DIAG_LATE_B12;
          end else if (only_b2) begin
            next_state    = BGB_ERROR;
            next_err_code = DIAG_LATE_B2;
          end else if (only_b1) begin
            next_state    = BGB_ERROR;
            next_err_code = DIAG_LATE_B1;
          end else begin
            next_state = BGB_RELEASED;
          end
        end else if (both_on) begin
          next_state = BGB_ACTUATED;
        end else if (none_on) begin
          next_state = BGB_RELEASED;
        end
      end
      BGB_ACTUATED: begin
        if (!both_on) begin
          next_state = BGB_LOCKED_OFF;
        end
      end
      BGB_LOCKED_OFF: begin
        // Both must be let go before a new press counts
        if (none_on) begin
          next_state = BGB_RELEASED;
        end
      end
      BGB_ERROR: begin
        if (none_on) begin
          next_state    = BGB_RELEASED;
          next_err_code = DIAG_IDLE;
        end
      end
      default: begin
        next_state = BGB_IDLE;
      end
    endcase
    if (!enable) begin
      next_state    = BGB_IDLE;
      next_err_code = DIAG_IDLE;
      win_start     = 1'b0;
    end
  end

  // Output decode from the next state so outputs align with state
  always_comb begin
    case (next_state)
      BGB_IDLE:       next_diag = DIAG_IDLE;
      BGB_INIT:       next_diag = DIAG_INIT;
      BGB_RELEASED:   next_diag = DIAG_RELEASED;
      BGB_FIRST_ON:   next_diag = DIAG_FIRST_ON;
      BGB_SECOND_ON:  next_diag = DIAG_SECOND_ON;
      BGB_ACTUATED:   next_diag = DIAG_ACTUATED;
      BGB_LOCKED_OFF: next_diag = DIAG_LOCKED_OFF;
      default:        next_diag = next_err_code;
    endcase
  end

  assign next_ready  = (next_state != BGB_IDLE);
  assign next_error  = (next_state == BGB_ERROR);
  assign next_permit = (next_state == BGB_ACTUATED);

  // Supervisor state and registered outputs, refreshed every cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state              <= BGB_IDLE;
      err_code           <= DIAG_IDLE;
      diagnostic_code    <= DIAG_IDLE;
      ready              <= 1'b0;
      error              <= 1'b0;
      release_permit_out <= 1'b0;
    end else begin
      state              <= next_state;
      err_code           <= next_err_code;
      diagnostic_code    <= next_diag;
      ready              <= next_ready;
      error              <= next_error;
      release_permit_out <= next_permit;
    end
  end

  // Events: error entered, release granted, release dropped
  assign events[EVT_ERROR_BIT] = next_error & !error;
  assign events[EVT_GRANT_BIT] = next_permit & !release_permit_out;
  assign events[EVT_DROP_BIT]  = !next_permit & release_permit_out;

  // ---- AXI4-Lite slave ----
  logic        aw_held;
  logic [3:0]  aw_addr_q;
  logic        w_held;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // Address and data are latched separately, in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  wire do_write = aw_held & w_held & !s_axi_bvalid;
  wire wr_ctrl  = do_write && (aw_addr_q == REG_CTRL);
  wire wr_irq   = do_write && (aw_addr_q == REG_IRQ_STATUS);
  wire wr_mask  = do_write && (aw_addr_q == REG_IRQ_MASK);
  wire wr_known = wr_ctrl || wr_irq || wr_mask || (aw_addr_q == REG_STATUS);
  wire byte0_en = w_strb_q[0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held   <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held    <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; status register is read-only but answers OKAY
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control and mask registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable   <= CTRL_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else begin
      if (wr_ctrl && byte0_en) begin
        enable <= w_data_q[CTRL_ENABLE_BIT];
      end
      if (wr_mask && byte0_en) begin
        irq_mask <= w_data_q[2:0];
      end
    end
  end

  // Sticky event bits; a new event beats a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_BITS; gi = gi + 1) begin : g_sticky
      wire clr = wr_irq && byte0_en && w_data_q[gi];
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          irq_status[gi] <= 1'b0;
        end else begin
          irq_status[gi] <= events[gi] | (irq_status[gi] & !clr);
        end
      end
    end
  endgenerate

  assign irq = |(irq_status & irq_mask);

  // Read data selection
  wire [31:0] status_word = {diagnostic_code, 11'h000, second_button_in, first_button_in,
                             release_permit_out, error, ready};
  wire rd_ctrl   = (s_axi_araddr == REG_CTRL);
  wire rd_status = (s_axi_araddr == REG_STATUS);
  wire rd_irq    = (s_axi_araddr == REG_IRQ_STATUS);
  wire rd_mask   = (s_axi_araddr == REG_IRQ_MASK);
  wire [31:0] rd_word = rd_ctrl   ? {31'h0000_0000, enable} :
                        rd_status ? status_word :
                        rd_irq    ? {29'h0000_0000, irq_status} :
                        rd_mask   ? {29'h0000_0000, irq_mask} : 32'h0000_0000;
  wire rd_known = rd_ctrl || rd_status || rd_irq || rd_mask;

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---- Assertions ----
  a_idle_priority: assert property (@(posedge clk) disable iff (reset)
    !enable |=> (state == BGB_IDLE))
    else $error("disable did not force idle");

  a_idle_outputs: assert property (@(posedge clk) disable iff (reset)
    (state == BGB_IDLE) |-> (diagnostic_code == 16'h0000) && !ready && !error
                            && !release_permit_out)
    else $error("idle outputs wrong");

  a_enable_b1_err: assert property (@(posedge clk) disable iff (reset)
    (enable && state == BGB_INIT && only_b1) |=>
      (diagnostic_code == 16'hC001) && ready && error && !release_permit_out)
    else $error("first button at enable not C001");

  a_enable_b2_err: assert property (@(posedge clk) disable iff (reset)
    (enable && state == BGB_INIT && only_b2) |=>
      (diagnostic_code == 16'hC002) && ready && error && !release_permit_out)
    else $error("second button at enable not C002");

  a_enable_both_err: assert property (@(posedge clk) disable iff (reset)
    (enable && state == BGB_INIT && both_on) |=> (diagnostic_code == 16'hC003) && error)
    else $error("both buttons at enable not C003");

  a_late_single: assert property (@(posedge clk) disable iff (reset)
    (enable && state == BGB_FIRST_ON && win_expired && !both_on && !none_on) |=>
      error && !release_permit_out &&
      (diagnostic_code == ($past(first_button_in) ? 16'hC005 : 16'hC004)))
    else $error("late single press code wrong");

  a_late_both: assert property (@(posedge clk) disable iff (reset)
    (enable && win_run && win_expired && both_on) |=>
      (diagnostic_code == 16'hC006) && error && !release_permit_out)
    else $error("late double press not C006");

  a_error_safe: assert property (@(posedge clk) disable iff (reset)
    error |-> !release_permit_out)
    else $error("release during error");

  a_error_stays: assert property (@(posedge clk) disable iff (reset)
    (error && enable && !none_on) |=> error && $stable(diagnostic_code))
    else $error("error cleared with a button held");

  a_grant_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(release_permit_out) |-> $past(both_on) && !error && ready
                                  && (diagnostic_code == 16'h8000))
    else $error("release without correct two-hand press");

  a_first_wait: assert property (@(posedge clk) disable iff (reset)
    (enable && state == BGB_RELEASED && only_b1) |=>
      (diagnostic_code == 16'h8005) && ready && !release_permit_out
      ##1 (!win_expired))
    else $error("first press state wrong");

  a_released_code: assert property (@(posedge clk) disable iff (reset)
    (state == BGB_RELEASED) |-> (diagnostic_code == 16'h8004) && ready && !error)
    else $error("released code wrong");

endmodule

// file: rtl/bgb_pkg.sv
// Shared constants and types for the two-hand guard block
package bgb_pkg;

  // Timing: controller clock and the two-hand window
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned MS_IN_NS        = 1000000;
  localparam int unsigned WINDOW_MS       = 500;
  localparam logic [15:0] CYCLES_PER_MS   = 16'(MS_IN_NS / CLK_PERIOD_NS);
  localparam logic [9:0]  WINDOW_MS_COUNT = 10'(WINDOW_MS);

  // Diagnostic codes, normal states
  localparam logic [15:0] DIAG_IDLE       = 16'h0000;
  localparam logic [15:0] DIAG_ACTUATED   = 16'h8000;
  localparam logic [15:0] DIAG_INIT       = 16'h8001;
  localparam logic [15:0] DIAG_RELEASED   = 16'h8004;
  localparam logic [15:0] DIAG_FIRST_ON   = 16'h8005;
  localparam logic [15:0] DIAG_SECOND_ON  = 16'h8006;
  localparam logic [15:0] DIAG_LOCKED_OFF = 16'h8009;

  // Diagnostic codes, error states
  localparam logic [15:0] DIAG_ERR_B1     = 16'hC001;
  localparam logic [15:0] DIAG_ERR_B2     = 16'hC002;
  localparam logic [15:0] DIAG_ERR_B12    = 16'hC003;
  localparam logic [15:0] DIAG_LATE_B2    = 16'hC004;
  localparam logic [15:0] DIAG_LATE_B1    = 16'hC005;
  localparam logic [15:0] DIAG_LATE_B12   = 16'hC006;

  // Register byte offsets
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h4;
  localparam logic [3:0]  REG_IRQ_STATUS  = 4'h8;
  localparam logic [3:0]  REG_IRQ_MASK    = 4'hC;

  // Field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned STAT_READY_BIT  = 0;
  localparam int unsigned STAT_ERROR_BIT  = 1;
  localparam int unsigned STAT_PERMIT_BIT = 2;
  localparam int unsigned STAT_B1_BIT     = 3;
  localparam int unsigned STAT_B2_BIT     = 4;
  localparam int unsigned STAT_DIAG_LSB   = 16;
  localparam int unsigned IRQ_BITS        = 3;
  localparam int unsigned EVT_ERROR_BIT   = 0;
  localparam int unsigned EVT_GRANT_BIT   = 1;
  localparam int unsigned EVT_DROP_BIT    = 2;

  // Reset values
  localparam logic        CTRL_RESET      = 1'b0;
  localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Supervisor states
  typedef enum logic [3:0] {
    BGB_IDLE,
    BGB_INIT,
    BGB_RELEASED,
    BGB_FIRST_ON,
    BGB_SECOND_ON,
    BGB_ACTUATED,
    BGB_LOCKED_OFF,
    BGB_ERROR
  } bgb_state_t;

endpackage

// file: rtl/bgb_window_timer.sv
// Millisecond window timer for the two-hand press interval
`timescale 1ns/100ps
module bgb_window_timer
  import bgb_pkg::*;
#(
  parameter logic [15:0] CYCLES_PER_MS_P = CYCLES_PER_MS
) (
  input  wire logic clk,      // Controller clock
  input  wire logic reset,    // Async reset, active high
  input  wire logic restart,  // Zero the window, one-cycle pulse
  input  wire logic run,      // Count while high
  output logic      expired   // Window has run out, level
);

  logic [15:0] tick_count;
  logic [9:0]  ms_count;
  logic        ms_tick;

  // Millisecond time base from the cycle clock
  assign ms_tick = (tick_count == (CYCLES_PER_MS_P - 16'h0001));
  assign expired = (ms_count == WINDOW_MS_COUNT);

  // Counter stops at expiry so the flag stays put until restart
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_count <= 16'h0000;
      ms_count   <= 10'h000;
    end else if (restart) begin
      tick_count <= 16'h0000;
      ms_count   <= 10'h000;
    end else if (run && !expired) begin
      tick_count <= ms_tick ? 16'h0000 : tick_count + 16'h0001;
      ms_count   <= ms_tick ? ms_count + 10'h001 : ms_count;
    end
  end

endmodule

// file: verif/bgb_button_model.sv
// Two-pushbutton partner model for the guard block bench
`timescale 1ns/100ps
module bgb_button_model (
  input  wire logic clk,              // Controller clock
  input  wire logic reset,            // Async reset, active high
  input  wire logic press_first,      // Operator holds first button
  input  wire logic press_second,     // Operator holds second button
  output logic      first_button_in,  // First contact, high = pressed
  output logic      second_button_in  // Second contact, high = pressed
);
  // Contacts follow the operator one clock late, as a real input stage would
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      first_button_in  <= 1'b0;
      second_button_in <= 1'b0;
    end else begin
      first_button_in  <= press_first;
      second_button_in <= press_second;
    end
  end
endmodule

// file: verif/test_bgb_guard_block.sv
// Self-checking bench for the two-hand guard block
`timescale 1ns/100ps
module test_bgb_guard_block;
  import bgb_pkg::*;
  localparam logic [15:0] CPM = 16'h0004;  // Short ms base, window 2000 cycles
  localparam int          WIN = 500 * 4;
  logic clk = 1'b0, reset = 1'b1, press_first = 1'b0, press_second = 1'b0;
  logic first_button_in, second_button_in, release_permit_out, ready, error, irq;
  logic [15:0] diagnostic_code, last_code = 16'h0000;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [18:0] sq[$];
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int error_cnt = 0, n_checks = 0, cyc = 0, seed = 32'h86bc;

  bgb_button_model pad (.clk, .reset, .press_first, .press_second,
    .first_button_in, .second_button_in);
  bgb_guard_block #(.CYCLES_PER_MS_P(CPM)) uut (.clk, .reset, .first_button_in,
    .second_button_in, .release_permit_out, .ready, .error, .diagnostic_code, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  always #10 clk = ~clk;

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Expected outputs derived from the code: error codes start C, permit only in 8000
  function automatic logic [18:0] st(input logic [15:0] c);
    return {c, c != 16'h0000, c[15:14] == 2'b11, c == DIAG_ACTUATED};
  endfunction

  // State watcher: each code change consumes the oldest expected state
  always @(negedge clk) begin
    if (!reset && diagnostic_code !== last_code) begin
      check("state", {diagnostic_code, ready, error, release_permit_out},
        (sq.size() != 0) ? sq.pop_front() : 19'h7FFFF);
      last_code = diagnostic_code;
    end
    if (error === 1'b1) check("permit", release_permit_out, 1'b0);
  end

  // Bus watcher at the handshake edges, values sampled before the edge updates
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() != 0)
      check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready && bq.size() != 0)
      check("bresp", s_axi_bresp, bq.pop_front());
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic ta, tw, tb;
    bq.push_back(resp);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] exp);
    logic ta, tr;
    rq.push_back(exp);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
  endtask

  task automatic btn(input logic f, input logic s);
    @(posedge clk);
    press_first  <= f;
    press_second <= s;
  endtask

  // Bounded wait until every expected state change has been seen
  task automatic settle(input int n);
    for (int i = 0; i < n && sq.size() != 0; i++) @(posedge clk);
    check("pending", sq.size(), 0);
  endtask

  task automatic irq_is(input logic v);
    @(negedge clk);
    check("irq", irq, v);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    // Reset values, read-only status and unmapped offsets
    rd(REG_CTRL, 34'h0);
    rd(REG_STATUS, 34'h0);
    rd(REG_IRQ_MASK, 34'h0);
    rd(4'h6, {RESP_SLVERR, 32'h0});
    wr(4'h2, 32'h1, RESP_SLVERR);
    wr(REG_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    // Correct two-hand operation with a random gap inside the window
    sq.push_back(st(DIAG_INIT));
    sq.push_back(st(DIAG_RELEASED));
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    settle(10);
    sq.push_back(st(DIAG_FIRST_ON));
    btn(1'b1, 1'b0);
    repeat (1 + {$random(seed)} % (WIN - 200)) @(posedge clk);
    sq.push_back(st(DIAG_ACTUATED));
    btn(1'b1, 1'b1);
    settle(10);
    rd(REG_STATUS, {2'b00, DIAG_ACTUATED, 16'h001D});
    rd(REG_IRQ_STATUS, 34'h2);
    irq_is(1'b0);
    wr(REG_IRQ_MASK, 32'h7, RESP_OKAY);
    irq_is(1'b1);
    sq.push_back(st(DIAG_LOCKED_OFF));
    sq.push_back(st(DIAG_RELEASED));
    btn(1'b0, 1'b1);
    btn(1'b0, 1'b0);
    settle(10);
    rd(REG_IRQ_STATUS, 34'h6);
    wr(REG_IRQ_STATUS, 32'h6, RESP_OKAY);
    rd(REG_IRQ_STATUS, 34'h0);
    irq_is(1'b0);
    // Window expiry with only the first button, then a swap held to expiry
    sq.push_back(st(DIAG_FIRST_ON));
    sq.push_back(st(DIAG_LATE_B1));
    btn(1'b1, 1'b0);
    settle(WIN + 50);
    rd(REG_IRQ_STATUS, 34'h1);
    irq_is(1'b1);
    sq.push_back(st(DIAG_RELEASED));
    btn(1'b0, 1'b0);
    settle(10);
    wr(REG_IRQ_STATUS, 32'h1, RESP_OKAY);
    sq.push_back(st(DIAG_FIRST_ON));
    sq.push_back(st(DIAG_LATE_B2));
    btn(1'b1, 1'b0);
    btn(1'b0, 1'b1);
    settle(WIN + 50);
    sq.push_back(st(DIAG_RELEASED));
    btn(1'b0, 1'b0);
    settle(10);
    // Second button alone, first joins in the very cycle the window runs out
    sq.push_back(st(DIAG_SECOND_ON));
    sq.push_back(st(DIAG_LATE_B12));
    btn(1'b0, 1'b1);
    repeat (WIN) @(posedge clk);
    btn(1'b1, 1'b1);
    settle(50);
    sq.push_back(st(DIAG_RELEASED));
    btn(1'b0, 1'b0);
    settle(10);
    // Disable in mid-press overrides everything
    sq.push_back(st(DIAG_FIRST_ON));
    btn(1'b1, 1'b0);
    settle(10);
    sq.push_back(st(DIAG_IDLE));
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    settle(10);
    // Buttons already pressed at enable, every combination
    for (int k = 1; k <= 3; k++) begin
      btn(k[0], k[1]);
      sq.push_back(st(DIAG_INIT));
      sq.push_back(st(16'hC000 | 16'(k)));
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      settle(10);
      sq.push_back(st(DIAG_IDLE));
      wr(REG_CTRL, 32'h0, RESP_OKAY);
      settle(10);
    end
    btn(1'b0, 1'b0);
    repeat (4) @(posedge clk);
    check("leftover", rq.size() + bq.size(), 0);
    tally_and_finish();
  end
endmodule
